/* hdl/ump_regs.vh */
`ifndef UMP_REGS_VH
`define UMP_REGS_VH

// Register addresses on the special-function register bus.
`define UMP_ADDR_CTRL 8'h98
`define UMP_ADDR_DATA 8'h99
`define UMP_ADDR_SLAVE 8'hA9
`define UMP_ADDR_MASK 8'hB9

// Reset values.
`define UMP_RST_CTRL 8'h00
`define UMP_RST_DATA 8'h00
`define UMP_RST_SLAVE 8'h00
`define UMP_RST_MASK 8'h00

// Bit positions inside serial_control.
`define UMP_BIT_FE_SM0 7
`define UMP_BIT_SM1 6
`define UMP_BIT_MPE 5
`define UMP_BIT_REN 4
`define UMP_BIT_TB8 3
`define UMP_BIT_RB8 2
`define UMP_BIT_TI 1
`define UMP_BIT_RI 0

// Mode field encodings.
`define UMP_MODE_SHIFT 2'h0
`define UMP_MODE_UART8 2'h1
`define UMP_MODE_UART9F 2'h2
`define UMP_MODE_UART9V 2'h3

// Divider reloads: mode 0 half-bit is 6 clocks, or 3 with double speed.
`define UMP_M0_HALF_STD 3'h5
`define UMP_M0_HALF_X2 3'h2
// Mode 2 oversample tick: 4 clocks gives clock/64, 2 clocks gives clock/32.
`define UMP_M2_OVS_STD 3'h3
`define UMP_M2_OVS_DBL 3'h1

// Oversampling and frame counts.
`define UMP_OVS_LAST 4'hF
`define UMP_OVS_MID 4'h7
`define UMP_M0_LAST_BIT 4'h7
`define UMP_FIFO_DEPTH 32
`define UMP_FIFO_AW 5

`endif

/* hdl/ump_tick.v */
module ump_tick #(
    parameter W = 3
) (
    input wire mclk_i,
    input wire sys_rst_i,
    input wire [W-1:0] reload_i,
    output reg tick_o
);
    reg [W-1:0] cnt_q;

    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cnt_q <= {W{1'b0}};
            tick_o <= 1'b0;
        end else if (cnt_q >= reload_i) begin
            cnt_q <= {W{1'b0}};
            tick_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
            tick_o <= 1'b0;
        end
    end
endmodule // ump_tick

/* hdl/ump_fifo.v */
module ump_fifo #(
    parameter W = 9,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire mclk_i,
    input wire sys_rst_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [W-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [W-1:0] out_data_o
);
    reg [W-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wptr_q;
    reg [AW-1:0] rptr_q;
    reg [AW:0] count_q;
    wire push;
    wire pop;

    assign in_ready_o = (count_q != DEPTH[AW:0]);
    assign out_valid_o = (count_q != {(AW+1){1'b0}});
    assign out_data_o = mem_q[rptr_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always @(posedge mclk_i) begin
        if (push) begin
            mem_q[wptr_q] <= in_data_i;
        end
    end

    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            wptr_q <= {AW{1'b0}};
            rptr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wptr_q <= wptr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rptr_q <= rptr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                count_q <= count_q + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                count_q <= count_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // ump_fifo

/* hdl/ump_core.v */
// Overview of operation
// - Given address: slave address bits compared only where the mask holds one.
// - Broadcast address is slave address OR mask; zero bits are don't-care.
// - Any slave whose given or broadcast pattern matches the address byte accepts it.
// - Mode field picks shift register, 8-bit UART, or 9-bit UART at fixed or variable rate.
// - Control bit 7 is framing error when select set, otherwise high mode bit.
// - Framing error set on bad stop bit, kept through good ones, cleared by software.
// - Multiprocessor enable turns on address recognition in modes 2 and 3.
// - Frames are received only while receive enable is set.
// - Mode 0 receive flag rises after the eighth bit; software clears it.
// - Control register resets to zero and each bit is writable by bit operation.
// - Data buffer write starts a transmit; read returns byte last taken from the receive queue.
// - Framing-error select decides whether bit 7 accesses error flag or mode bit.
// - With framing detection on, receive flag rises on stop bit, not last data bit.
`include "ump_regs.vh"

module ump_core (
    input wire mclk_i,
    input wire sys_rst_i,
    input wire [7:0] sfr_addr_i,
    input wire sfr_wr_i,
    input wire sfr_rd_i,
    input wire [7:0] sfr_wdata_i,
    input wire sfr_bit_wr_i,
    input wire [2:0] sfr_bit_sel_i,
    input wire sfr_bit_val_i,
    output reg [7:0] sfr_rdata_o,
    input wire framing_error_select_i,
    input wire double_speed_mode_i,
    input wire baud_double_i,
    input wire baud16_tick_i,
    input wire rxd_i,
    output reg rxd_o,
    output reg rxd_oe_o,
    output reg txd_o,
    output wire tx_interrupt_flag_o,
    output wire rx_interrupt_flag_o
);
    localparam SH_IDLE = 2'h0;
    localparam SH_M0 = 2'h1;
    localparam SH_ASYNC = 2'h2;
    localparam RX_IDLE = 1'b0;
    localparam RX_BITS = 1'b1;

    reg mode_bit_high_q;
    reg framing_error_flag_q;
    reg mode_bit_low_q;
    reg multiproc_enable_q;
    reg rx_enable_q;
    reg tx_ninth_bit_q;
    reg rx_ninth_bit_q;
    reg tx_interrupt_flag_q;
    reg rx_interrupt_flag_q;
    reg [7:0] slave_address_q;
    reg [7:0] slave_address_mask_q;
    reg [7:0] rx_buffer_q;

    reg rxd_meta_q;
    reg rxd_sync_q;
    reg rxd_prev_q;

    reg [1:0] sh_state_q;
    reg [10:0] sh_q;
    reg [3:0] sh_cnt_q;
    reg [3:0] sh_sub_q;
    reg sh_half_q;
    reg sh_m0_rx_q;
    reg ti_set_q;
    reg push_m0_q;

    reg rx_state_q;
    reg [7:0] rx_sh_q;
    reg rx_nin_q;
    reg [3:0] rx_cnt_q;
    reg [3:0] rx_sub_q;
    reg push_rx_q;
    reg [8:0] push_rx_data_q;
    reg fe_set_q;

    wire [1:0] mode;
    wire nine;
    wire fe_sel;
    wire m0_tick;
    wire m2_tick;
    wire tick16;
    wire [7:0] ctrl_rd;
    reg [7:0] ctrl_bit;
    wire [7:0] ctrl_w;
    wire ctrl_wr;
    wire data_wr;
    wire [3:0] tx_last;
    wire [3:0] rx_last_data;
    wire [3:0] rx_stop_idx;
    wire [7:0] rx_byte_w;
    wire rx_nin_w;
    wire given_match;
    wire bcast_match;
    wire [7:0] bcast_addr;
    wire rx_accept;
    wire fifo_in_valid;
    wire fifo_in_ready;
    wire [8:0] fifo_in_data;
    wire fifo_out_valid;
    wire fifo_out_ready;
    wire [8:0] fifo_out_data;

    assign mode = {mode_bit_high_q, mode_bit_low_q};
    assign nine = mode[1];
    assign fe_sel = framing_error_select_i;
    assign tick16 = (mode == `UMP_MODE_UART9F) ? m2_tick : baud16_tick_i;
    assign tx_last = nine ? 4'hA : 4'h9;
    assign rx_last_data = nine ? 4'h9 : 4'h8;
    assign rx_stop_idx = nine ? 4'hA : 4'h9;
    assign tx_interrupt_flag_o = tx_interrupt_flag_q;
    assign rx_interrupt_flag_o = rx_interrupt_flag_q;

    ump_tick #(.W(3)) u_m0_tick (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .reload_i(double_speed_mode_i ? `UMP_M0_HALF_X2 : `UMP_M0_HALF_STD),
        .tick_o(m0_tick)
    );

    ump_tick #(.W(3)) u_m2_tick (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .reload_i(baud_double_i ? `UMP_M2_OVS_DBL : `UMP_M2_OVS_STD),
        .tick_o(m2_tick)
    );

    // Bit 7 shows whichever of the two flops the select bit points at.
    assign ctrl_rd = {fe_sel ? framing_error_flag_q : mode_bit_high_q,
                      mode_bit_low_q, multiproc_enable_q, rx_enable_q,
                      tx_ninth_bit_q, rx_ninth_bit_q,
                      tx_interrupt_flag_q, rx_interrupt_flag_q};

    always @* begin
        ctrl_bit = ctrl_rd;
        ctrl_bit[sfr_bit_sel_i] = sfr_bit_val_i;
    end

    assign ctrl_wr = (sfr_wr_i || sfr_bit_wr_i) && (sfr_addr_i == `UMP_ADDR_CTRL);
    assign ctrl_w = sfr_bit_wr_i ? ctrl_bit : sfr_wdata_i;
    assign data_wr = sfr_wr_i && (sfr_addr_i == `UMP_ADDR_DATA);

    // Hardware set wins over a software write in the same cycle.
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            mode_bit_high_q <= 1'b0;
            framing_error_flag_q <= 1'b0;
            mode_bit_low_q <= 1'b0;
            multiproc_enable_q <= 1'b0;
            rx_enable_q <= 1'b0;
            tx_ninth_bit_q <= 1'b0;
            rx_ninth_bit_q <= 1'b0;
            tx_interrupt_flag_q <= 1'b0;
            rx_interrupt_flag_q <= 1'b0;
            slave_address_q <= `UMP_RST_SLAVE;
            slave_address_mask_q <= `UMP_RST_MASK;
            rx_buffer_q <= `UMP_RST_DATA;
        end else begin
            if (ctrl_wr) begin
                if (!fe_sel) begin
                    mode_bit_high_q <= ctrl_w[`UMP_BIT_FE_SM0];
                end
                mode_bit_low_q <= ctrl_w[`UMP_BIT_SM1];
                multiproc_enable_q <= ctrl_w[`UMP_BIT_MPE];
                rx_enable_q <= ctrl_w[`UMP_BIT_REN];
                tx_ninth_bit_q <= ctrl_w[`UMP_BIT_TB8];
            end
            if (fe_set_q) begin
                framing_error_flag_q <= 1'b1;
            end else if (ctrl_wr && fe_sel) begin
                framing_error_flag_q <= ctrl_w[`UMP_BIT_FE_SM0];
            end
            if (ti_set_q) begin
                tx_interrupt_flag_q <= 1'b1;
            end else if (ctrl_wr) begin
                tx_interrupt_flag_q <= ctrl_w[`UMP_BIT_TI];
            end
            if (fifo_out_valid && fifo_out_ready) begin
                rx_interrupt_flag_q <= 1'b1;
                rx_ninth_bit_q <= fifo_out_data[8];
                rx_buffer_q <= fifo_out_data[7:0];
            end else if (ctrl_wr) begin
                rx_interrupt_flag_q <= ctrl_w[`UMP_BIT_RI];
                rx_ninth_bit_q <= ctrl_w[`UMP_BIT_RB8];
            end
            if (sfr_wr_i && sfr_addr_i == `UMP_ADDR_SLAVE) begin
                slave_address_q <= sfr_wdata_i;
            end
            if (sfr_wr_i && sfr_addr_i == `UMP_ADDR_MASK) begin
                slave_address_mask_q <= sfr_wdata_i;
            end
        end
    end

    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (sfr_rd_i) begin
            case (sfr_addr_i)
                `UMP_ADDR_CTRL: sfr_rdata_o <= ctrl_rd;
                `UMP_ADDR_DATA: sfr_rdata_o <= rx_buffer_q;
                `UMP_ADDR_SLAVE: sfr_rdata_o <= slave_address_q;
                `UMP_ADDR_MASK: sfr_rdata_o <= slave_address_mask_q;
                default: sfr_rdata_o <= 8'h00;
            endcase
        end
    end

    // The serial input is a pin, so it passes two flops first.
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rxd_meta_q <= 1'b1;
            rxd_sync_q <= 1'b1;
            rxd_prev_q <= 1'b1;
        end else begin
            rxd_meta_q <= rxd_i;
            rxd_sync_q <= rxd_meta_q;
            rxd_prev_q <= rxd_sync_q;
        end
    end

    // Transmitter, plus the mode 0 shifter which also receives on the data pin.
    // A data write while busy is dropped; in modes 1 to 3 that includes the stop bit, which is still being sent after the transmit flag rises.
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            sh_state_q <= SH_IDLE;
            sh_q <= 11'h7FF;
            sh_cnt_q <= 4'h0;
            sh_sub_q <= 4'h0;
            sh_half_q <= 1'b0;
            sh_m0_rx_q <= 1'b0;
            ti_set_q <= 1'b0;
            push_m0_q <= 1'b0;
            txd_o <= 1'b1;
            rxd_o <= 1'b1;
            rxd_oe_o <= 1'b0;
        end else begin
            ti_set_q <= 1'b0;
            push_m0_q <= 1'b0;
            case (sh_state_q)
                SH_IDLE: begin
                    txd_o <= 1'b1;
                    rxd_oe_o <= 1'b0;
                    sh_cnt_q <= 4'h0;
                    sh_sub_q <= 4'h0;
                    sh_half_q <= 1'b0;
                    if (data_wr && mode == `UMP_MODE_SHIFT) begin
                        sh_state_q <= SH_M0;
                        sh_m0_rx_q <= 1'b0;
                        sh_q <= {3'h7, sfr_wdata_i};
                        rxd_o <= sfr_wdata_i[0];
                        rxd_oe_o <= 1'b1;
                    end else if (data_wr) begin
                        sh_state_q <= SH_ASYNC;
                        sh_q <= {1'b1, nine ? tx_ninth_bit_q : 1'b1, sfr_wdata_i, 1'b0};
                        txd_o <= 1'b0;
                    end else if (mode == `UMP_MODE_SHIFT && rx_enable_q &&
                                 !rx_interrupt_flag_q && fifo_in_ready) begin
                        sh_state_q <= SH_M0;
                        sh_m0_rx_q <= 1'b1;
                    end
                end
                SH_M0: begin
                    if (m0_tick) begin
                        sh_half_q <= ~sh_half_q;
                        if (!sh_half_q) begin
                            txd_o <= 1'b0;
                        end else begin
                            txd_o <= 1'b1;
                            sh_cnt_q <= sh_cnt_q + 4'h1;
                            if (sh_m0_rx_q) begin
                                sh_q <= {3'h7, rxd_sync_q, sh_q[7:1]};
                            end else begin
                                sh_q <= {1'b1, sh_q[10:1]};
                                rxd_o <= sh_q[1];
                            end
                            if (sh_cnt_q == `UMP_M0_LAST_BIT) begin
                                sh_state_q <= SH_IDLE;
                                rxd_oe_o <= 1'b0;
                                ti_set_q <= !sh_m0_rx_q;
                                push_m0_q <= sh_m0_rx_q;
                            end
                        end
                    end
                end
                SH_ASYNC: begin
                    if (tick16) begin
                        sh_sub_q <= sh_sub_q + 4'h1;
                        if (sh_sub_q == `UMP_OVS_LAST) begin
                            if (sh_cnt_q == tx_last) begin
                                sh_state_q <= SH_IDLE;
                                txd_o <= 1'b1;
                            end else begin
                                sh_q <= {1'b1, sh_q[10:1]};
                                txd_o <= sh_q[1];
                                sh_cnt_q <= sh_cnt_q + 4'h1;
                                ti_set_q <= (sh_cnt_q + 4'h1 == tx_last);
                            end
                        end
                    end
                end
                default: begin
                    sh_state_q <= SH_IDLE;
                end
            endcase
        end
    end

    // Address recognition on the byte as it stands when the frame completes.
    assign rx_byte_w = (rx_cnt_q == 4'h8) ? {rxd_sync_q, rx_sh_q[7:1]} : rx_sh_q;
    assign rx_nin_w = (nine && rx_cnt_q == 4'h9) ? rxd_sync_q : rx_nin_q;
    assign given_match = ((rx_byte_w ^ slave_address_q) & slave_address_mask_q) == 8'h00;
    assign bcast_addr = slave_address_q | slave_address_mask_q;
    assign bcast_match = (rx_byte_w & bcast_addr) == bcast_addr;
    assign rx_accept = !(multiproc_enable_q && nine) ||
                       (rx_nin_w && (given_match || bcast_match));

    // Asynchronous receiver, sampling each bit at mid oversample count.
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rx_state_q <= RX_IDLE;
            rx_sh_q <= 8'h00;
            rx_nin_q <= 1'b0;
            rx_cnt_q <= 4'h0;
            rx_sub_q <= 4'h0;
            push_rx_q <= 1'b0;
            push_rx_data_q <= 9'h000;
            fe_set_q <= 1'b0;
        end else begin
            push_rx_q <= 1'b0;
            fe_set_q <= 1'b0;
            case (rx_state_q)
                RX_IDLE: begin
                    rx_cnt_q <= 4'h0;
                    rx_sub_q <= 4'h0;
                    rx_nin_q <= 1'b0;
                    if (rx_enable_q && mode != `UMP_MODE_SHIFT && rxd_prev_q &&
                        !rxd_sync_q && fifo_in_ready && !push_rx_q) begin
                        rx_state_q <= RX_BITS;
                    end
                end
                RX_BITS: begin
                    if (tick16) begin
                        rx_sub_q <= rx_sub_q + 4'h1;
                        if (rx_sub_q == `UMP_OVS_MID) begin
                            rx_cnt_q <= rx_cnt_q + 4'h1;
                            if (rx_cnt_q == 4'h0 && rxd_sync_q) begin
                                rx_state_q <= RX_IDLE;
                            end
                            if (rx_cnt_q >= 4'h1 && rx_cnt_q <= 4'h8) begin
                                rx_sh_q <= {rxd_sync_q, rx_sh_q[7:1]};
                            end
                            rx_nin_q <= rx_nin_w;
                            if ((rx_cnt_q == rx_last_data && !fe_sel) ||
                                (rx_cnt_q == rx_stop_idx && fe_sel)) begin
                                push_rx_q <= rx_accept;
                                push_rx_data_q <= {rx_nin_w, rx_byte_w};
                            end
                            if (rx_cnt_q == rx_stop_idx) begin
                                rx_state_q <= RX_IDLE;
                                fe_set_q <= fe_sel && !rxd_sync_q;
                            end
                        end
                    end
                    if (!rx_enable_q) begin
                        rx_state_q <= RX_IDLE;
                    end
                end
                default: begin
                    rx_state_q <= RX_IDLE;
                end
            endcase
        end
    end

    // Received frames queue here; one is handed over each time software clears
    // the receive flag, so a slow reader loses nothing until 32 frames wait.
    assign fifo_in_valid = push_m0_q || push_rx_q;
    assign fifo_in_data = push_m0_q ? {1'b0, sh_q[7:0]} : push_rx_data_q;
    assign fifo_out_ready = !rx_interrupt_flag_q;

    ump_fifo #(
        .W(9),
        .DEPTH(`UMP_FIFO_DEPTH),
        .AW(`UMP_FIFO_AW)
    ) u_rx_fifo (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in_data),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );
endmodule // ump_core

/* bench/ump_core_sva.sv */
`include "ump_regs.vh"
module ump_core_sva (
    input wire mclk_i,
    input wire sys_rst_i,
    input wire [7:0] sfr_addr_i,
    input wire sfr_wr_i,
    input wire sfr_rd_i,
    input wire [7:0] sfr_wdata_i,
    input wire sfr_bit_wr_i,
    input wire [7:0] sfr_rdata_o,
    input wire rxd_oe_o,
    input wire txd_o,
    input wire tx_interrupt_flag_o,
    input wire rx_interrupt_flag_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    wire ctrl_sw = (sfr_wr_i || sfr_bit_wr_i) && sfr_addr_i == `UMP_ADDR_CTRL;
    wire mapped = sfr_addr_i == `UMP_ADDR_CTRL || sfr_addr_i == `UMP_ADDR_DATA
        || sfr_addr_i == `UMP_ADDR_SLAVE || sfr_addr_i == `UMP_ADDR_MASK;
    AST_RST_STATE: assert property (disable iff (1'b0) sys_rst_i |=>
        txd_o && !rxd_oe_o && !tx_interrupt_flag_o && !rx_interrupt_flag_o && sfr_rdata_o == 8'h00)
        else $error("outputs not cleared by reset");
    AST_RDATA_HOLD: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
        else $error("read data moved without a read");
    AST_UNMAPPED_RD: assert property (sfr_rd_i && !mapped |=> sfr_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    AST_SLAVE_RW: assert property (sfr_wr_i && sfr_addr_i == `UMP_ADDR_SLAVE ##1 !sfr_wr_i
        ##1 sfr_rd_i && sfr_addr_i == `UMP_ADDR_SLAVE |=> sfr_rdata_o == $past(sfr_wdata_i, 3))
        else $error("slave address readback wrong");
    AST_MASK_RW: assert property (sfr_wr_i && sfr_addr_i == `UMP_ADDR_MASK ##1 !sfr_wr_i
        ##1 sfr_rd_i && sfr_addr_i == `UMP_ADDR_MASK |=> sfr_rdata_o == $past(sfr_wdata_i, 3))
        else $error("mask readback wrong");
    AST_TXF_HOLD: assert property (tx_interrupt_flag_o && !ctrl_sw && !$past(ctrl_sw)
        |=> tx_interrupt_flag_o) else $error("transmit flag dropped by itself");
    AST_RXF_HOLD: assert property (rx_interrupt_flag_o && !ctrl_sw && !$past(ctrl_sw)
        |=> rx_interrupt_flag_o) else $error("receive flag dropped by itself");
    AST_TXF_RISE: assert property ($rose(tx_interrupt_flag_o) |-> txd_o
        || $past(ctrl_sw) || $past(ctrl_sw, 2)) else $error("transmit flag rose outside stop");
endmodule // ump_core_sva

bind ump_core ump_core_sva u_ump_core_sva (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_bit_wr_i(sfr_bit_wr_i), .sfr_rdata_o(sfr_rdata_o),
    .rxd_oe_o(rxd_oe_o), .txd_o(txd_o), .tx_interrupt_flag_o(tx_interrupt_flag_o),
    .rx_interrupt_flag_o(rx_interrupt_flag_o));

/* bench/ump_peer.sv */
module ump_peer #(
    parameter int BIT_CLKS = 32
) (
    input wire logic mclk_i,
    input wire logic line_i,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial line_o = 1'b1;
    // A bad stop bit is sent only when a scenario asks for one; idle is high.
    task automatic send(input logic [7:0] b, input logic ninth, input logic stop);
        logic [10:0] f;
        f = {stop, ninth, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge mclk_i) line_o <= f[i];
            repeat (BIT_CLKS - 1) @(posedge mclk_i);
        end
        @(posedge mclk_i) line_o <= 1'b1;
    endtask
    // Samples on the falling edge so the line has settled.
    task automatic recv(output logic [9:0] w);
        int n;
        n = 0;
        w = 10'h000;
        while (line_i !== 1'b0 && n < 4000) begin
            @(negedge mclk_i);
            n++;
        end
        repeat (BIT_CLKS / 2) @(negedge mclk_i);
        for (int i = 0; i < 10; i++) begin
            repeat (BIT_CLKS) @(negedge mclk_i);
            w[i] = line_i;
        end
    endtask
endmodule // ump_peer

/* bench/ump_core_tb.sv */
`include "ump_regs.vh"
module ump_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] sfr_addr_i = 8'h00;
    logic [7:0] sfr_wdata_i = 8'h00;
    logic sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, sfr_bit_wr_i = 1'b0, sfr_bit_val_i = 1'b0;
    logic [2:0] sfr_bit_sel_i = 3'h0;
    logic framing_error_select_i = 1'b0, baud16_tick_i = 1'b0, double_speed_mode_i = 1'b0;
    logic [1:0] tick_div = 2'h0;
    wire [7:0] sfr_rdata_o;
    wire rxd_o, rxd_oe_o, txd_o, tx_interrupt_flag_o, rx_interrupt_flag_o, peer_line;
    // Mode 0 transmit takes the shared data pin away from the peer.
    wire rxd_pin = rxd_oe_o ? rxd_o : peer_line;
    int n_mismatch = 0;
    int check_count = 0;
    always #12.5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        tick_div <= tick_div + 2'h1;
        baud16_tick_i <= (tick_div == 2'h3);
    end
    ump_core u_ump_core (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sfr_addr_i(sfr_addr_i),
        .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
        .sfr_bit_wr_i(sfr_bit_wr_i), .sfr_bit_sel_i(sfr_bit_sel_i), .sfr_bit_val_i(sfr_bit_val_i),
        .sfr_rdata_o(sfr_rdata_o), .framing_error_select_i(framing_error_select_i),
        .double_speed_mode_i(double_speed_mode_i),
        .baud_double_i(1'b1), .baud16_tick_i(baud16_tick_i),
        .rxd_i(rxd_pin), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o),
        .tx_interrupt_flag_o(tx_interrupt_flag_o), .rx_interrupt_flag_o(rx_interrupt_flag_o));
    ump_peer #(.BIT_CLKS(32)) u_ump_peer (.mclk_i(mclk_i), .line_i(txd_o), .line_o(peer_line));
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i) {sfr_addr_i, sfr_wdata_i, sfr_wr_i} <= {a, d, 1'b1};
        @(posedge mclk_i) sfr_wr_i <= 1'b0;
    endtask
    task automatic bw(input logic [2:0] s, input logic v);
        @(posedge mclk_i) {sfr_addr_i, sfr_bit_sel_i, sfr_bit_val_i, sfr_bit_wr_i} <= {8'h98, s, v, 1'b1};
        @(posedge mclk_i) sfr_bit_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_i) {sfr_addr_i, sfr_rd_i} <= {a, 1'b1};
        @(posedge mclk_i) sfr_rd_i <= 1'b0;
        @(negedge mclk_i) d = sfr_rdata_o;
    endtask
    task automatic rx_wait(output logic seen);
        seen = 1'b0;
        repeat (40) @(negedge mclk_i) if (rx_interrupt_flag_o === 1'b1) seen = 1'b1;
    endtask
    function automatic logic hit(input logic [7:0] b, input logic [7:0] a, input logic [7:0] m);
        return (((b ^ a) & m) == 8'h00) || ((b & (a | m)) == (a | m));
    endfunction
    task automatic t_regs;
        logic [7:0] d;
        for (int i = 0; i < 5; i++) begin
            rd(i == 4 ? 8'h00 : (i == 0 ? 8'h98 : i == 1 ? 8'h99 : i == 2 ? 8'hA9 : 8'hB9), d);
            chk(10'(d), 10'h000);
        end
        wr(8'hA9, 8'h5A);
        rd(8'hA9, d);
        chk(10'(d), 10'h05A);
        wr(8'hB9, 8'hC3);
        rd(8'hB9, d);
        chk(10'(d), 10'h0C3);
    endtask
    task automatic t_addr(input logic [7:0] a, input logic [7:0] m);
        logic [7:0] tbl [6] = '{8'hF0, 8'hF3, 8'hFF, 8'hFB, 8'h56, 8'h57};
        logic seen;
        logic [7:0] d;
        wr(8'hA9, a);
        wr(8'hB9, m);
        wr(8'h98, 8'hB0);
        foreach (tbl[i]) begin
            u_ump_peer.send(tbl[i], 1'b1, 1'b1);
            rx_wait(seen);
            chk(10'(seen), 10'(hit(tbl[i], a, m)));
            if (seen) begin
                rd(8'h99, d);
                chk(10'(d), 10'(tbl[i]));
                rd(8'h98, d);
                chk(10'(d[2]), 10'h001);
                bw(3'h0, 1'b0);
            end
        end
        u_ump_peer.send(a, 1'b0, 1'b1);
        rx_wait(seen);
        chk(10'(seen), 10'h000);
    endtask
    task automatic t_ren;
        logic seen;
        wr(8'h98, 8'hA0);
        u_ump_peer.send(8'hFF, 1'b1, 1'b1);
        rx_wait(seen);
        chk(10'(seen), 10'h000);
    endtask
    task automatic t_fe;
        logic seen;
        logic [7:0] d;
        wr(8'h98, 8'h90);
        @(posedge mclk_i) framing_error_select_i <= 1'b1;
        u_ump_peer.send(8'h3C, 1'b0, 1'b0);
        rx_wait(seen);
        chk(10'(seen), 10'h001);
        rd(8'h98, d);
        chk(10'(d[7]), 10'h001);
        bw(3'h0, 1'b0);
        u_ump_peer.send(8'hC3, 1'b0, 1'b1);
        rx_wait(seen);
        chk(10'(seen), 10'h001);
        bw(3'h0, 1'b0);
        rd(8'h98, d);
        chk(10'(d[7]), 10'h001);
        bw(3'h7, 1'b0);
        rd(8'h98, d);
        chk(10'(d[7]), 10'h000);
        @(posedge mclk_i) framing_error_select_i <= 1'b0;
        rd(8'h98, d);
        chk(10'(d[7]), 10'h001);
    endtask
    task automatic t_tx;
        logic [9:0] w;
        time t0;
        wr(8'h98, 8'h98);
        wr(8'h99, 8'hA5);
        u_ump_peer.recv(w);
        chk(w, 10'h3A5);
        chk(10'(tx_interrupt_flag_o), 10'h001);
        bw(3'h1, 1'b0);
        // The stop bit must finish first, or the next data write is dropped.
        repeat (24) @(negedge mclk_i);
        chk(10'(tx_interrupt_flag_o), 10'h000);
        wr(8'h98, 8'h00);
        @(posedge mclk_i) double_speed_mode_i <= 1'b1;
        wr(8'h99, 8'h81);
        t0 = $time;
        @(negedge mclk_i);
        chk(10'(rxd_oe_o), 10'h001);
        for (int i = 0; i < 8; i++) begin
            @(negedge txd_o);
            @(negedge mclk_i) w[i] = rxd_o;
        end
        chk(10'(w[7:0]), 10'h081);
        chk(10'($time - t0 < 1500), 10'h001);
        repeat (150) @(negedge mclk_i);
        chk(10'(tx_interrupt_flag_o), 10'h001);
    endtask
    task automatic complete_run;
        if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        t_regs;
        t_addr(8'hF1, 8'hFA);
        t_addr(8'h56, 8'hFF);
        t_ren;
        t_fe;
        t_tx;
        complete_run;
    end
    // Roughly twenty frames of 352 clocks fit well inside this limit.
    initial begin
        repeat (30000) @(posedge mclk_i);
        n_mismatch++;
        complete_run;
    end
endmodule // ump_core_tb
